// [common/iap_defs.svh]
// Constants for the analog-input and address port block
// Overview of operation
// - Analog port: eight input-only pins, no driver
// - Reset sets analog latch bits, analog mode
// - Latch bit zero gives high-impedance digital input
// - Pins feed timer2 count, trigger, slave select
// - Address port follows latch, with pull-ups
// - Program fetch drives middle address byte
// - Data access drives middle and high bytes
// - Drive select one: push-pull from address bus
// - External accesses never modify address latch
// - Reads return latch or pin per signal
`ifndef IAP_DEFS_SVH
`define IAP_DEFS_SVH
`define IAP_ANALOG_RESET   8'hff
`define IAP_ADDRESS_RESET  8'hff
`define IAP_BIT_T2_COUNT   0
`define IAP_BIT_T2_TRIG    1
`define IAP_BIT_SLAVE_SEL  5
`define IAP_SEL_FETCH_HI   2'h0
`define IAP_SEL_DATA_MID   2'h1
`define IAP_SEL_DATA_HI    2'h2
`endif

// [common/iap_pkg.sv]
// Types for the analog-input and address port block
package iap_pkg;
  typedef enum logic [1:0] {
    IAP_ADDR_FETCH_HI = 2'b00,
    IAP_ADDR_DATA_MID = 2'b01,
    IAP_ADDR_DATA_HI  = 2'b10,
    IAP_ADDR_RSVD     = 2'b11
  } iap_addr_sel_t;
endpackage

// [core/iap_ports.sv]
// Analog-capable input port and bidirectional address port
`timescale 1ns/1ps
`default_nettype none
`include "iap_defs.svh"
module iap_ports
  import iap_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic                 CORE_CLK,        // Core clock, 125 MHz
  input  wire logic                 RST_N,           // Synchronous reset, active low
  input  wire logic                 AP_WRITE,        // Write pulse to analog latch
  input  wire logic                 DP_WRITE,        // Write pulse to address latch
  input  wire logic [WIDTH-1:0]     WRITE_DATA,      // Data for latch writes
  input  wire logic                 READ_PIN,        // 1 reads pins, 0 reads latch
  input  wire logic [WIDTH-1:0]     AP_PIN_IN,       // Analog port pin levels
  input  wire logic [WIDTH-1:0]     DP_PIN_IN,       // Address port pin levels
  input  wire logic                 EXT_MEM_DRIVE,   // External memory drive select
  input  wire iap_pkg::iap_addr_sel_t ADDR_SEL,      // Which address byte to drive
  input  wire logic [23:0]          EXT_ADDR,        // Internal 24-bit address bus
  output logic [WIDTH-1:0]          AP_READ,         // Analog port read data
  output logic [WIDTH-1:0]          DP_READ,         // Address port read data
  output logic [WIDTH-1:0]          AP_ANALOG_EN,    // Per-pin analog mode select
  output logic [WIDTH-1:0]          DP_PIN_OUT,      // Address port pin output
  output logic [WIDTH-1:0]          DP_PIN_OE,       // High while pin driven hard
  output logic [WIDTH-1:0]          DP_PULLUP_EN,    // Weak pull-up enable
  output logic                      T2_COUNT_IN,     // Timer2 external count input
  output logic                      T2_TRIGGER_IN,   // Timer2 capture/reload trigger
  output logic                      SLAVE_SELECT_N   // Serial slave select, active low
);
  logic [WIDTH-1:0] analog_port_latch;
  logic [WIDTH-1:0] address_port_latch;
  logic [WIDTH-1:0] ap_s1, ap_s2, ap_s3, ap_clean;
  logic [WIDTH-1:0] dp_s1, dp_s2, dp_s3, dp_clean;
  logic [WIDTH-1:0] next_ap_clean;
  logic [WIDTH-1:0] next_dp_clean;
  logic [WIDTH-1:0] addr_byte;

  // How the block is organised:
  // The analog-capable port has no output stage at all. Its latch only
  // chooses, per pin, between analog mode (latch bit 1) and a plain
  // high-impedance digital input (latch bit 0). The mode select leaves
  // the block registered so the pad control never sees a glitch.
  // The address port has a latch that software owns. While an external
  // memory cycle is in progress the pins are driven hard from the
  // internal address bus; the latch is left alone, so its value is back
  // on the pins at the first clock edge after the drive select falls.
  // Both ports read either the latch or the filtered pin level, picked
  // by one read-select input that the instruction decoder supplies.
  // Pins are asynchronous to the core clock: each passes three flops and
  // a change is taken only once the second and third flops agree. That
  // costs five cycles of latency on every pin read and alternate input,
  // a price paid to keep metastable or one-cycle glitches out of timer 2
  // and the serial slave-select logic.

  // Read-back selection shared by both ports: pin level or latch contents
  function automatic logic [WIDTH-1:0] read_select(
    input logic             pin_sel,
    input logic [WIDTH-1:0] pin_level,
    input logic [WIDTH-1:0] latch_value
  );
    if (pin_sel)
      read_select = pin_level;
    else
      read_select = latch_value;
  endfunction

  // Address byte decode; code 3 is unused and falls back to the fetch byte
  function automatic logic [7:0] addr_pick(
    input iap_addr_sel_t sel,
    input logic [23:0]   addr
  );
    case (sel)
      IAP_ADDR_FETCH_HI: addr_pick = addr[15:8];
      IAP_ADDR_DATA_MID: addr_pick = addr[15:8];
      IAP_ADDR_DATA_HI:  addr_pick = addr[23:16];
      default:           addr_pick = addr[15:8];
    endcase
  endfunction

  // Analog latch; reset to all ones puts every pin in analog mode
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      analog_port_latch <= `IAP_ANALOG_RESET;
    else if (AP_WRITE)
      analog_port_latch <= WRITE_DATA;
  end

  // Address latch; only software writes touch it, never bus cycles
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      address_port_latch <= `IAP_ADDRESS_RESET;
    else if (DP_WRITE)
      address_port_latch <= WRITE_DATA;
  end

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ap_s1    <= '0;
      ap_s2    <= '0;
      ap_s3    <= '0;
      ap_clean <= '0;
      dp_s1    <= '0;
      dp_s2    <= '0;
      dp_s3    <= '0;
      dp_clean <= '0;
    end
    else
    begin
      ap_s1    <= AP_PIN_IN;
      ap_s2    <= ap_s1;
      ap_s3    <= ap_s2;
      ap_clean <= next_ap_clean;
      dp_s1    <= DP_PIN_IN;
      dp_s2    <= dp_s1;
      dp_s3    <= dp_s2;
      dp_clean <= next_dp_clean;
    end
  end

  // Per-bit agreement filter, so a one-cycle glitch is not taken
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_filt
      assign next_ap_clean[gi] = (ap_s2[gi] == ap_s3[gi]) ? ap_s2[gi] : ap_clean[gi];
      assign next_dp_clean[gi] = (dp_s2[gi] == dp_s3[gi]) ? dp_s2[gi] : dp_clean[gi];
    end
  endgenerate

  // Address byte chosen by the kind of external access
  // The byte follows the bus combinationally and is registered at the pins
  always_comb
  begin
    addr_byte = addr_pick(ADDR_SEL, EXT_ADDR);
  end

  // Read paths; analog-mode pins read their filtered level too, software
  // must clear the latch bit for the value to mean anything
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      AP_READ <= '0;
      DP_READ <= '0;
    end
    else
    begin
      AP_READ <= read_select(READ_PIN, ap_clean, analog_port_latch);
      DP_READ <= read_select(READ_PIN, dp_clean, address_port_latch);
    end
  end

  // Analog port has no driver; only the mode select leaves the block
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      AP_ANALOG_EN <= `IAP_ANALOG_RESET;
    else
      AP_ANALOG_EN <= analog_port_latch;
  end

  // Address port pins: push-pull from bus in memory mode, else latch with pull-ups.
  // Port mode drives only zeros hard; ones rely on the pull-up, as quasi-bidirectional.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      DP_PIN_OUT   <= `IAP_ADDRESS_RESET;
      DP_PIN_OE    <= '0;
      DP_PULLUP_EN <= '1;
    end
    else if (EXT_MEM_DRIVE)
    begin
      DP_PIN_OUT   <= addr_byte;
      DP_PIN_OE    <= '1;
      DP_PULLUP_EN <= '0;
    end
    else
    begin
      DP_PIN_OUT   <= address_port_latch;
      DP_PIN_OE    <= ~address_port_latch;
      DP_PULLUP_EN <= '1;
    end
  end

  // Alternate functions taken from filtered pin levels.
  // They follow the pins whatever the latch mode, so a pin left in analog
  // mode still feeds timer 2 or slave select; software must pick one use.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      T2_COUNT_IN    <= 1'b0;
      T2_TRIGGER_IN  <= 1'b0;
      SLAVE_SELECT_N <= 1'b1;
    end
    else
    begin
      T2_COUNT_IN    <= ap_clean[`IAP_BIT_T2_COUNT];
      T2_TRIGGER_IN  <= ap_clean[`IAP_BIT_T2_TRIG];
      SLAVE_SELECT_N <= ap_clean[`IAP_BIT_SLAVE_SEL];
    end
  end
endmodule
`default_nettype wire

// [testbench/iap_ports_assertions.sv]
// Port timing checker for the analog and address port block
`timescale 1ns/1ps
`default_nettype none
module iap_chk
  import iap_pkg::*;
(
  input wire logic CORE_CLK, RST_N, AP_WRITE, DP_WRITE, READ_PIN, EXT_MEM_DRIVE,
  input wire logic T2_COUNT_IN, T2_TRIGGER_IN, SLAVE_SELECT_N,
  input wire logic [7:0] WRITE_DATA, AP_PIN_IN, AP_READ, AP_ANALOG_EN, DP_PIN_OUT, DP_PIN_OE,
  input wire iap_addr_sel_t ADDR_SEL,
  input wire logic [23:0] EXT_ADDR
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  property p_rst;
    $rose(RST_N) |-> AP_ANALOG_EN == 8'hff;
  endproperty
  a_rst: assert property (p_rst) else $error("analog mode after reset");
  property p_apw;
    AP_WRITE ##1 !AP_WRITE |=> AP_ANALOG_EN == $past(WRITE_DATA, 2);
  endproperty
  a_apw: assert property (p_apw) else $error("analog latch write");
  property p_dpw;
    DP_WRITE ##1 !(DP_WRITE || EXT_MEM_DRIVE) |=> DP_PIN_OE == ~$past(WRITE_DATA, 2);
  endproperty
  a_dpw: assert property (p_dpw) else $error("address latch drive");
  property p_fetch;
    EXT_MEM_DRIVE && ADDR_SEL != IAP_ADDR_DATA_HI |=> DP_PIN_OUT == $past(EXT_ADDR[15:8]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("middle byte");
  property p_dhi;
    EXT_MEM_DRIVE && ADDR_SEL == IAP_ADDR_DATA_HI |=> DP_PIN_OE == 8'hff
      && DP_PIN_OUT == $past(EXT_ADDR[23:16]);
  endproperty
  a_dhi: assert property (p_dhi) else $error("high byte");
  // Latch value must come back unchanged once the access ends
  property p_keep;
    (!DP_WRITE && !EXT_MEM_DRIVE)[*2] ##1 (!DP_WRITE && EXT_MEM_DRIVE)[*2]
      ##1 !(DP_WRITE || EXT_MEM_DRIVE) |=> DP_PIN_OUT == $past(DP_PIN_OUT, 4);
  endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  // Seven quiet cycles cover the synchronizer depth
  property p_alt;
    (READ_PIN && $stable(AP_PIN_IN))[*7] |-> AP_READ == AP_PIN_IN && SLAVE_SELECT_N == AP_PIN_IN[5]
      && T2_COUNT_IN == AP_PIN_IN[0] && T2_TRIGGER_IN == AP_PIN_IN[1];
  endproperty
  a_alt: assert property (p_alt) else $error("pin level");
  property p_lrd;
    (!READ_PIN && !AP_WRITE)[*3] |-> AP_READ == AP_ANALOG_EN;
  endproperty
  a_lrd: assert property (p_lrd) else $error("latch read");
endmodule
bind iap_ports iap_chk u_chk (.*);
`default_nettype wire

// [testbench/iap_board.sv]
// Board model for the pins of both ports
`timescale 1ns/1ps
`default_nettype none
module iap_board (
  input  wire logic [7:0] drive_ap, // Levels applied to analog pins
  input  wire logic [7:0] out,      // Address port output value
  input  wire logic [7:0] oe,       // Address port hard drive
  input  wire logic [7:0] pu,       // Pull-up enable
  output var logic [7:0]  ap_pin,   // Analog pin levels
  output var logic [7:0]  dp_pin    // Resolved address pins
);
  // Floating unpulled pins show the inverse, so stale values never pass
  always_comb
  begin
    ap_pin = drive_ap;
    for (int i = 0; i < 8; i++)
      dp_pin[i] = oe[i] ? out[i] : (pu[i] ? 1'b1 : ~out[i]);
  end
endmodule
`default_nettype wire

// [testbench/iap_ports_tb_top.sv]
// Self-checking bench for the analog and address port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module iap_ports_tb_top;
  import iap_pkg::*;
  logic clk = 0, rst_n = 0, apw = 0, dpw = 0, rdp = 0, emd = 0, t2c, t2t, ssn;
  logic [7:0] wd = 0, pins = 0, apin, dpin, ap_rd, ap_en, dp_out, dp_oe, dp_pu, dp_rd;
  logic [23:0] ea = 0;
  iap_addr_sel_t sel = IAP_ADDR_FETCH_HI;
  int errors = 0, tests_run = 0;
  always #4 clk = ~clk;
  iap_ports dut (.CORE_CLK(clk), .RST_N(rst_n), .AP_WRITE(apw), .DP_WRITE(dpw),
    .WRITE_DATA(wd), .READ_PIN(rdp), .AP_PIN_IN(apin), .DP_PIN_IN(dpin), .EXT_MEM_DRIVE(emd),
    .ADDR_SEL(sel), .EXT_ADDR(ea), .AP_READ(ap_rd), .DP_READ(dp_rd), .AP_ANALOG_EN(ap_en),
    .DP_PIN_OUT(dp_out), .DP_PIN_OE(dp_oe), .DP_PULLUP_EN(dp_pu), .T2_COUNT_IN(t2c),
    .T2_TRIGGER_IN(t2t), .SLAVE_SELECT_N(ssn));
  iap_board brd (.drive_ap(pins), .out(dp_out), .oe(dp_oe), .pu(dp_pu), .ap_pin(apin),
    .dp_pin(dpin));
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Latch write, then pin reads and alternate inputs after the synchronizer
  task automatic t_analog;
    `CHK("analog_en", 8'hff, ap_en)
    apw = 1;
    wd = 8'h5a;
    step(1);
    apw = 0;
    step(1);
    `CHK("analog_en", 8'h5a, ap_en)
    `CHK("latch_read", 8'h5a, ap_rd)
    rdp = 1;
    pins = 8'h21;
    step(8);
    `CHK("pin_read", 8'h21, ap_rd)
    `CHK("alt_in", 3'b101, {ssn, t2t, t2c})
    pins = 8'h02;
    step(8);
    `CHK("alt_in", 3'b010, {ssn, t2t, t2c})
    rdp = 0;
    $display("analog test done");
  endtask
  // Every select code in turn, then the latch must return
  task automatic t_addr;
    logic [7:0] want;
    dpw = 1;
    wd = 8'h0f;
    step(1);
    dpw = 0;
    step(2);
    `CHK("dp_pin", 8'h0f, dpin)
    ea = 24'ha5_c35a;
    emd = 1;
    for (int s = 0; s < 4; s++)
    begin
      sel = iap_addr_sel_t'(s);
      step(1);
      want = (s == 2) ? 8'ha5 : 8'hc3;
      `CHK("addr_pin", want, dpin)
    end
    `CHK("dp_read", 8'h0f, dp_rd)
    emd = 0;
    step(1);
    `CHK("dp_pin", 8'h0f, dpin)
    // Two-cycle access between quiet cycles
    step(1);
    emd = 1;
    step(2);
    emd = 0;
    step(1);
    `CHK("dp_pin_short", 8'h0f, dpin)
    rdp = 1;
    step(6);
    `CHK("dp_pin_read", 8'h0f, dp_rd)
    rdp = 0;
    $display("address test done");
  endtask
  // Main sequence
  initial
  begin
    step(4);
    rst_n = 1;
    t_analog;
    t_addr;
    tally_and_finish;
  end
  // Watchdog, far beyond the few dozen cycles the tests take
  initial
  begin
    #8000;
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
